/* File: acp_pkg.sv */
// Package: register map and field layout for converter config and pin control
package acp_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [3:0] OFS_CONFIG = 4'h0;
   localparam logic [3:0] OFS_PIN_DIS = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   // ----------------------------------------------------------------
   // Config field positions
   // ----------------------------------------------------------------
   localparam int POS_LOW_POWER = 7;
   localparam int POS_DIV_HI = 6;
   localparam int POS_DIV_LO = 5;
   localparam int POS_LONG_SAMPLE = 4;
   localparam int POS_MODE_HI = 3;
   localparam int POS_MODE_LO = 2;
   localparam int POS_SRC_HI = 1;
   localparam int POS_SRC_LO = 0;
   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_CONFIG = 8'h00;
   localparam logic [7:0] RST_PIN_DIS = 8'h00;
   localparam logic [3:0] RST_RATIO = 4'h1;
   localparam logic [1:0] MODE_8BIT = 2'h0;
   localparam logic [1:0] MODE_10BIT = 2'h2;
   localparam logic [1:0] SRC_BUS = 2'h0;
   localparam logic [1:0] SRC_BUS_HALF = 2'h1;
   localparam logic [1:0] SRC_ALT = 2'h2;
   localparam logic [1:0] SRC_ASYNC = 2'h3;
   localparam int NUM_PINS = 8;
endpackage

/* File: acp_top.sv */
// Module: config and analog pin control registers with a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module acp_top (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic conversion_done,
   output logic low_power_select,
   output logic [1:0] clock_divide_select,
   output logic [3:0] divide_ratio,
   output logic long_sample_select,
   output logic [1:0] mode_select,
   output logic [1:0] clock_source_select,
   output logic [7:0] port_release,
   output logic result_invalid
);
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic [7:0] config_reg, config_next;
   logic [7:0] pin_reg, pin_next;
   logic inval_reg, inval_next;
   logic ack_reg;
   logic [31:0] rdat_reg;
   // Gating with ack stops a held request from being taken twice
   wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire wr_lane0 = req & wb_we_i & wb_sel_i[0];
   wire hit_cfg = wb_adr_i == acp_pkg::OFS_CONFIG;
   wire hit_pin = wb_adr_i == acp_pkg::OFS_PIN_DIS;
   wire hit_sts = wb_adr_i == acp_pkg::OFS_STATUS;
   wire [1:0] new_mode = wb_dat_i[acp_pkg::POS_MODE_HI:acp_pkg::POS_MODE_LO];
   wire [1:0] cur_mode =
      config_reg[acp_pkg::POS_MODE_HI:acp_pkg::POS_MODE_LO];
   wire cfg_wr = wr_lane0 & hit_cfg;
   // Reserved mode codes are stored as written; software must avoid them
   wire mode_change = cfg_wr & (new_mode != cur_mode);
   wire [31:0] rdat_mux =
      hit_cfg ? {24'h000000, config_reg} :
      hit_pin ? {24'h000000, pin_reg} :
      hit_sts ? {31'h00000000, inval_reg} : 32'h00000000;
   // Unmapped addresses still ack with zero data so the bus never hangs
   assign config_next = cfg_wr ? wb_dat_i[7:0] : config_reg;
   assign pin_next = (wr_lane0 & hit_pin) ? wb_dat_i[7:0] : pin_reg;
   // A mode change wins over a completion in the same cycle
   assign inval_next = mode_change ? 1'b1 :
      conversion_done ? 1'b0 : inval_reg;
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         config_reg <= acp_pkg::RST_CONFIG;
         pin_reg <= acp_pkg::RST_PIN_DIS;
         inval_reg <= 1'b0;
         ack_reg <= 1'b0;
         rdat_reg <= 32'h00000000;
      end else begin
         config_reg <= config_next;
         pin_reg <= pin_next;
         inval_reg <= inval_next;
         ack_reg <= req;
         rdat_reg <= rdat_mux;
      end
   end
   // ----------------------------------------------------------------
   // Decoded outputs, each from a flip-flop
   // ----------------------------------------------------------------
   logic [3:0] ratio_reg;
   logic [7:0] release_reg;
   wire [1:0] div_next =
      config_next[acp_pkg::POS_DIV_HI:acp_pkg::POS_DIV_LO];
   wire [3:0] ratio_next = 4'h1 << div_next;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ratio_reg <= acp_pkg::RST_RATIO;
         release_reg <= 8'h00;
      end else begin
         ratio_reg <= ratio_next;
         release_reg <= pin_next;
      end
   end
   // Pin release is registered alongside the control bit, so no lag
   genvar gi;
   generate
      for (gi = 0; gi < acp_pkg::NUM_PINS; gi++) begin : g_pin
         assign port_release[gi] = release_reg[gi];
      end
   endgenerate
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
   assign low_power_select = config_reg[acp_pkg::POS_LOW_POWER];
   assign clock_divide_select =
      config_reg[acp_pkg::POS_DIV_HI:acp_pkg::POS_DIV_LO];
   assign divide_ratio = ratio_reg;
   assign long_sample_select = config_reg[acp_pkg::POS_LONG_SAMPLE];
   assign mode_select = cur_mode;
   assign clock_source_select =
      config_reg[acp_pkg::POS_SRC_HI:acp_pkg::POS_SRC_LO];
   assign result_invalid = inval_reg;
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_ratio_match: assert property (
      @(posedge clk_sys) disable iff (reset)
      divide_ratio == (4'h1 << clock_divide_select))
      else $error("divide ratio does not match divide code");
   a_pin_release: assert property (
      @(posedge clk_sys) disable iff (reset)
      port_release == pin_reg)
      else $error("port release differs from pin control");
   a_pin_write: assert property (
      @(posedge clk_sys) disable iff (reset)
      (wr_lane0 && hit_pin) |=> pin_reg == $past(wb_dat_i[7:0]))
      else $error("pin control write lost");
   a_cfg_write: assert property (
      @(posedge clk_sys) disable iff (reset)
      cfg_wr |=> {low_power_select, clock_divide_select,
      long_sample_select, mode_select, clock_source_select}
      == $past(wb_dat_i[7:0]))
      else $error("config write not reflected");
   a_cfg_hold: assert property (
      @(posedge clk_sys) disable iff (reset)
      !cfg_wr |=> $stable(config_reg))
      else $error("config changed without write");
   a_mode_inval: assert property (
      @(posedge clk_sys) disable iff (reset)
      mode_change |=> result_invalid)
      else $error("mode change did not invalidate results");
   a_inval_clear: assert property (
      @(posedge clk_sys) disable iff (reset)
      (result_invalid && conversion_done && !mode_change)
      |=> !result_invalid)
      else $error("completion did not revalidate results");
   // Not disabled by reset: it checks what reset itself leaves behind
   a_reset_vals: assert property (
      @(posedge clk_sys)
      reset |=> config_reg == acp_pkg::RST_CONFIG
      && pin_reg == acp_pkg::RST_PIN_DIS
      && clock_source_select == acp_pkg::SRC_BUS)
      else $error("reset values wrong");
   // The edge after reset may move a field with no write or invalidation
   a_mode_legal: assert property (
      @(posedge clk_sys) disable iff (reset)
      ($changed(mode_select) && !$past(reset)) |-> result_invalid)
      else $error("mode changed without invalidation");
   a_src_hold: assert property (
      @(posedge clk_sys) disable iff (reset)
      ($changed(clock_source_select) && !$past(reset)) |-> $past(cfg_wr))
      else $error("clock source changed without write");
   a_ack_pulse: assert property (
      @(posedge clk_sys) disable iff (reset)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");
   // Bus answer comes exactly one cycle after the taking edge
   a_ack_latency: assert property (
      @(posedge clk_sys) disable iff (reset)
      req |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_ack_cause: assert property (
      @(posedge clk_sys) disable iff (reset)
      !req |=> !wb_ack_o)
      else $error("ack without a request");
   a_cfg_read: assert property (
      @(posedge clk_sys) disable iff (reset)
      (req && !wb_we_i && hit_cfg)
      |=> wb_dat_o == {24'h000000, $past(config_reg)})
      else $error("config read data wrong");
   a_pin_read: assert property (
      @(posedge clk_sys) disable iff (reset)
      (req && !wb_we_i && hit_pin)
      |=> wb_dat_o == {24'h000000, $past(pin_reg)})
      else $error("pin control read data wrong");
   a_status_read: assert property (
      @(posedge clk_sys) disable iff (reset)
      (req && !wb_we_i && hit_sts)
      |=> wb_dat_o == {31'h00000000, $past(inval_reg)})
      else $error("status read data wrong");
   a_pin_hold: assert property (
      @(posedge clk_sys) disable iff (reset)
      !(wr_lane0 && hit_pin) |=> $stable(pin_reg))
      else $error("pin control changed without write");
   // Writes with the low byte lane off must leave both registers alone
   a_lane_ignore: assert property (
      @(posedge clk_sys) disable iff (reset)
      (req && wb_we_i && !wb_sel_i[0])
      |=> $stable(config_reg) && $stable(pin_reg))
      else $error("write with low lane off took effect");
   a_inval_hold: assert property (
      @(posedge clk_sys) disable iff (reset)
      (!mode_change && !conversion_done) |=> $stable(inval_reg))
      else $error("result flag changed with no cause");
   a_reset_outs: assert property (
      @(posedge clk_sys)
      reset |=> divide_ratio == acp_pkg::RST_RATIO && !result_invalid
      && !wb_ack_o && port_release == acp_pkg::RST_PIN_DIS)
      else $error("outputs not cleared by reset");
   c_mode_10: cover property (@(posedge clk_sys)
      cfg_wr && new_mode == acp_pkg::MODE_10BIT);
   c_async_src: cover property (@(posedge clk_sys)
      clock_source_select == acp_pkg::SRC_ASYNC);
   c_all_pins: cover property (@(posedge clk_sys) port_release == 8'hFF);
   c_revalid: cover property (@(posedge clk_sys)
      result_invalid ##1 !result_invalid);
   c_set_wins: cover property (@(posedge clk_sys)
      mode_change && conversion_done);
endmodule
`default_nettype wire

/* File: acp_top_tb.sv */
// Testbench for the converter config and pin control registers
`timescale 1ns/1ps
`default_nettype none
module acp_top_tb;
   logic clk_sys = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic conversion_done = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0, divide_ratio;
   logic [31:0] dat = 32'h0, wb_dat_o, q;
   logic wb_ack_o, low_power_select, long_sample_select, result_invalid;
   logic [1:0] clock_divide_select, mode_select, clock_source_select;
   logic [7:0] port_release;
   int err_total = 0, checks_done = 0;
   // Row: config byte, expected divide ratio, expected result flag
   logic [15:0] rows [4] = '{16'h0010, 16'hB921, 16'h4A41, 16'hE381};
   always #2.5 clk_sys = ~clk_sys;
   acp_top i_acp_top (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .conversion_done(conversion_done), .low_power_select(low_power_select),
      .clock_divide_select(clock_divide_select), .divide_ratio(divide_ratio),
      .long_sample_select(long_sample_select), .mode_select(mode_select),
      .clock_source_select(clock_source_select),
      .port_release(port_release), .result_invalid(result_invalid));
   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, s);
         err_total++;
      end
   endtask
   // Ack and read data are taken at the edge, before that edge's updates
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
         input logic [7:0] d);
      int n = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat <= {24'h0, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      #1;
      chk("ack_wait", 32'h2, n);
      chk("ack_drop", 32'h0, {31'h0, wb_ack_o});
   endtask
   task automatic chk_cfg(input logic [7:0] c);
      chk("low_power", {31'h0, c[7]}, {31'h0, low_power_select});
      chk("div_sel", {30'h0, c[6:5]}, {30'h0, clock_divide_select});
      chk("div_ratio", 32'h1 << c[6:5], {28'h0, divide_ratio});
      chk("long_smp", {31'h0, c[4]}, {31'h0, long_sample_select});
      chk("mode", {30'h0, c[3:2]}, {30'h0, mode_select});
      chk("src", {30'h0, c[1:0]}, {30'h0, clock_source_select});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic pulse_done;
      @(posedge clk_sys);
      conversion_done <= 1'b1;
      @(posedge clk_sys);
      conversion_done <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask
   // ----------------------------------------------------------------
   // Watchdog: the whole sequence needs under a hundred cycles
   // ----------------------------------------------------------------
   initial begin
      repeat (3000) @(posedge clk_sys);
      err_total++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      chk_cfg(8'h00);
      chk("pins", 32'h0, {24'h0, port_release});
      chk("inv_reset", 32'h0, {31'h0, result_invalid});
      $display("reset test done");
      foreach (rows[i]) begin
         wb(1'b1, 4'h0, 4'hF, rows[i][15:8]);
         chk_cfg(rows[i][15:8]);
         chk("ratio_row", {28'h0, rows[i][7:4]}, {28'h0, divide_ratio});
         chk("inv_row", {28'h0, rows[i][3:0]}, {31'h0, result_invalid});
         wb(1'b0, 4'h0, 4'hF, 8'h00);
         chk("cfg_read", {24'h0, rows[i][15:8]}, q);
      end
      $display("config table test done");
      wb(1'b1, 4'h4, 4'hF, 8'hFF);
      chk("release_all", 32'hFF, {24'h0, port_release});
      wb(1'b1, 4'h4, 4'hF, 8'hA5);
      chk("release", 32'hA5, {24'h0, port_release});
      wb(1'b1, 4'h4, 4'hE, 8'h5A);
      wb(1'b0, 4'h4, 4'hF, 8'h00);
      chk("pin_read", 32'hA5, q);
      wb(1'b1, 4'hC, 4'hF, 8'hFF);
      wb(1'b0, 4'hC, 4'hF, 8'h00);
      chk("unmapped", 32'h0, q);
      chk_cfg(8'hE3);
      $display("pin and unmapped test done");
      pulse_done();
      chk("invalid_clr", 32'h0, {31'h0, result_invalid});
      wb(1'b1, 4'h0, 4'hF, 8'hEB);
      chk("invalid_set", 32'h1, {31'h0, result_invalid});
      wb(1'b1, 4'h0, 4'hF, 8'h6B);
      wb(1'b0, 4'h8, 4'hF, 8'h00);
      chk("status", 32'h1, q);
      pulse_done();
      chk("invalid_done", 32'h0, {31'h0, result_invalid});
      $display("resolution change test done");
      // A completion in the very cycle of a mode change: the set wins
      fork
         wb(1'b1, 4'h0, 4'hF, 8'h63);
         begin
            @(posedge clk_sys);
            conversion_done <= 1'b1;
            @(posedge clk_sys);
            conversion_done <= 1'b0;
         end
      join
      chk("set_wins", 32'h1, {31'h0, result_invalid});
      chk_cfg(8'h63);
      $display("write and completion test done");
      @(posedge clk_sys);
      reset <= 1'b1;
      @(posedge clk_sys);
      @(posedge clk_sys);
      reset <= 1'b0;
      #1;
      chk_cfg(8'h00);
      chk("pins_rst", 32'h0, {24'h0, port_release});
      chk("inv_rst", 32'h0, {31'h0, result_invalid});
      wb(1'b0, 4'h8, 4'hF, 8'h00);
      chk("status_rst", 32'h0, q);
      $display("second reset test done");
      finish_test();
   end
endmodule
`default_nettype wire
